// >>> rtl/ata_card_command_and_control.sv
// ATA task-file command interpreter with AXI4-Lite register access
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ata_card_command_and_control #(
    parameter bit CARD_IS_SLAVE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irqReq_ff,
    output logic [3:0] mediaOp_ff,
    output logic mediaStrobe_ff
);
    localparam int WCW = $clog2(ata_cmd_pkg::SECTOR_WORDS + 1);

    ata_cmd_pkg::task_file_t taskFile_ff;
    ata_cmd_pkg::status_t status_ff;
    ata_cmd_pkg::op_t op_ff;
    logic [7:0] ctl_ff;
    logic [7:0] config_ff;
    logic [7:0] error_ff;
    logic [7:0] lastCmd_ff;
    logic [7:0] powerMode_ff;
    logic intPending_ff;
    logic [$clog2(ata_cmd_pkg::EXEC_CYCLES + 1)-1:0] execCnt_ff;
    logic [WCW-1:0] wordCnt_ff;
    logic [15:0] recCyl_ff;
    logic [3:0] recHead_ff;

    logic [7:0] awAddr_ff;
    logic awHeld_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic wHeld_ff;
    logic [7:0] arAddr_ff;
    logic arHeld_ff;

    logic soft_reset_bit;
    logic wrFire;
    logic rdFire;
    logic [7:0] wrByte;
    logic selected;
    logic cmdAccept;
    logic dataWrite;
    logic dataRead;
    logic statusRead;
    ata_cmd_pkg::op_t nxt_op;
    logic rangeBad;

    assign soft_reset_bit = ctl_ff[ata_cmd_pkg::SOFT_RESET_POS];
    assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign rdFire = arHeld_ff && !s_axi_rvalid;
    assign wrByte = wStrb_ff[0] ? wData_ff[7:0] : 8'h00;
    assign selected = taskFile_ff.drvHead[ata_cmd_pkg::CARD_SELECT_POS] == CARD_IS_SLAVE;
    assign cmdAccept = wrFire && wStrb_ff[0] && awAddr_ff == ata_cmd_pkg::ADDR_CMDSTAT
                       && !status_ff.busy && !soft_reset_bit && selected;
    assign dataWrite = wrFire && awAddr_ff == ata_cmd_pkg::ADDR_DATA && status_ff.dataReq
                       && (op_ff == ata_cmd_pkg::OP_WRITE || op_ff == ata_cmd_pkg::OP_FORMAT);
    assign dataRead = rdFire && arAddr_ff == ata_cmd_pkg::ADDR_DATA && status_ff.dataReq
                      && (op_ff == ata_cmd_pkg::OP_READ || op_ff == ata_cmd_pkg::OP_IDENTIFY);
    assign statusRead = rdFire && arAddr_ff == ata_cmd_pkg::ADDR_CMDSTAT;

    // Sector number range 01H..20H, head 0..3; count needs no check
    always_comb begin
        rangeBad = taskFile_ff.secNum < ata_cmd_pkg::SECNUM_MIN
                   || taskFile_ff.secNum > ata_cmd_pkg::SECNUM_MAX
                   || taskFile_ff.drvHead[3:0] > ata_cmd_pkg::HEAD_MAX;
    end

    always_comb begin
        unique case (wrByte)
            ata_cmd_pkg::CMD_CHECK_POWER_A, ata_cmd_pkg::CMD_CHECK_POWER_B: nxt_op = ata_cmd_pkg::OP_POWER;
            ata_cmd_pkg::CMD_DIAGNOSE: nxt_op = ata_cmd_pkg::OP_DIAG;
            ata_cmd_pkg::CMD_ERASE: nxt_op = ata_cmd_pkg::OP_ERASE;
            ata_cmd_pkg::CMD_FORMAT: nxt_op = ata_cmd_pkg::OP_FORMAT;
            ata_cmd_pkg::CMD_IDENTIFY: nxt_op = ata_cmd_pkg::OP_IDENTIFY;
            ata_cmd_pkg::CMD_READ_MULTI, ata_cmd_pkg::CMD_READ_LONG_A, ata_cmd_pkg::CMD_READ_LONG_B,
            ata_cmd_pkg::CMD_READ_A, ata_cmd_pkg::CMD_READ_B: nxt_op = ata_cmd_pkg::OP_READ;
            ata_cmd_pkg::CMD_VERIFY_A, ata_cmd_pkg::CMD_VERIFY_B: nxt_op = ata_cmd_pkg::OP_VERIFY;
            ata_cmd_pkg::CMD_WRITE_MULTI, ata_cmd_pkg::CMD_WRITE_MULTI_NE, ata_cmd_pkg::CMD_WRITE_NE,
            ata_cmd_pkg::CMD_WRITE_VERIFY: nxt_op = ata_cmd_pkg::OP_WRITE;
            default: nxt_op = ata_cmd_pkg::OP_BAD;
        endcase
    end

    // AXI write channel capture; address and data may arrive in either order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !wHeld_ff && !(s_axi_wvalid && s_axi_wready);
        end
    end
    assign s_axi_bresp = 2'b00;

    // Read channel
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arHeld_ff <= 1'b0;
            arAddr_ff <= 8'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !arHeld_ff && !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                arHeld_ff <= 1'b1;
                arAddr_ff <= s_axi_araddr;
            end
            if (rdFire) begin
                arHeld_ff <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                unique case (arAddr_ff)
                    ata_cmd_pkg::ADDR_DATA: s_axi_rdata <= {16'h0000, readWord()};
                    ata_cmd_pkg::ADDR_FEATURE: s_axi_rdata <= {24'h0, error_ff};
                    ata_cmd_pkg::ADDR_SECCOUNT: s_axi_rdata <= {24'h0, taskFile_ff.secCount};
                    ata_cmd_pkg::ADDR_SECNUM: s_axi_rdata <= {24'h0, taskFile_ff.secNum};
                    ata_cmd_pkg::ADDR_CYLLOW: s_axi_rdata <= {24'h0, taskFile_ff.cylinder[7:0]};
                    ata_cmd_pkg::ADDR_CYLHIGH: s_axi_rdata <= {24'h0, taskFile_ff.cylinder[15:8]};
                    ata_cmd_pkg::ADDR_DRVHEAD: s_axi_rdata <= {24'h0, taskFile_ff.drvHead};
                    ata_cmd_pkg::ADDR_CMDSTAT, ata_cmd_pkg::ADDR_CTLALT: s_axi_rdata <= {24'h0, statusByte()};
                    // Undefined bits read zero here
                    ata_cmd_pkg::ADDR_HEADECHO: s_axi_rdata <= {26'h0, ~taskFile_ff.drvHead[3:0], 2'b00};
                    ata_cmd_pkg::ADDR_CONFIG: s_axi_rdata <= {24'h0, config_ff};
                    ata_cmd_pkg::ADDR_CMDINFO: s_axi_rdata <= {8'h0, recHead_ff, 4'h0, recCyl_ff};
                    ata_cmd_pkg::ADDR_MODE: s_axi_rdata <= {16'h0, lastCmd_ff, powerMode_ff};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    function automatic logic [7:0] statusByte();
        statusByte = {status_ff.busy, status_ff.ready, 1'b0, status_ff.seekDone,
                      status_ff.dataReq, 2'b00, status_ff.error};
    endfunction : statusByte

    // Identify block: small parameter set, rest zero
    function automatic logic [15:0] readWord();
        logic [WCW-1:0] idx;
        idx = WCW'(ata_cmd_pkg::SECTOR_WORDS) - wordCnt_ff;
        if (op_ff != ata_cmd_pkg::OP_IDENTIFY) begin
            readWord = 16'h0000;
        end else if (idx == WCW'(49)) begin
            readWord = 16'h0200;
        end else if (idx == WCW'(3)) begin
            readWord = 16'h0004;
        end else if (idx == WCW'(6)) begin
            readWord = {8'h00, ata_cmd_pkg::SECNUM_MAX};
        end else begin
            readWord = 16'h0000;
        end
    endfunction : readWord

    // Device control; hardware reset only, soft reset cannot clear itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_ff <= ata_cmd_pkg::CTL_RESET;
        end else if (wrFire && wStrb_ff[0] && awAddr_ff == ata_cmd_pkg::ADDR_CTLALT) begin
            ctl_ff <= {4'h0, 1'b1, wrByte[2:1], 1'b0};
        end
    end

    // Configuration survives soft reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            config_ff <= ata_cmd_pkg::CONFIG_RESET;
        end else if (wrFire && wStrb_ff[0] && awAddr_ff == ata_cmd_pkg::ADDR_CONFIG) begin
            config_ff <= wrByte;
        end
    end

    // Task file: held in reset while soft reset set
    always_ff @(posedge ref_clk) begin
        if (rst || soft_reset_bit) begin
            taskFile_ff <= '{8'h00, ata_cmd_pkg::SECCOUNT_RESET, ata_cmd_pkg::SECNUM_RESET, 16'h0000,
                             ata_cmd_pkg::DRVHEAD_RESET};
        end else if (wrFire && wStrb_ff[0] && !status_ff.busy) begin
            unique case (awAddr_ff)
                ata_cmd_pkg::ADDR_FEATURE: taskFile_ff.feature <= wrByte;
                ata_cmd_pkg::ADDR_SECCOUNT: taskFile_ff.secCount <= wrByte;
                ata_cmd_pkg::ADDR_SECNUM: taskFile_ff.secNum <= wrByte;
                ata_cmd_pkg::ADDR_CYLLOW: taskFile_ff.cylinder[7:0] <= wrByte;
                ata_cmd_pkg::ADDR_CYLHIGH: taskFile_ff.cylinder[15:8] <= wrByte;
                ata_cmd_pkg::ADDR_DRVHEAD: taskFile_ff.drvHead <= wrByte;
                default: ;
            endcase
        end
    end

    // Command execution
    always_ff @(posedge ref_clk) begin
        if (rst || soft_reset_bit) begin
            status_ff <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            op_ff <= ata_cmd_pkg::OP_NONE;
            error_ff <= 8'h00;
            lastCmd_ff <= 8'h00;
            execCnt_ff <= '0;
            wordCnt_ff <= '0;
            mediaOp_ff <= 4'h0;
            mediaStrobe_ff <= 1'b0;
        end else begin
            mediaStrobe_ff <= 1'b0;
            if (cmdAccept) begin
                op_ff <= nxt_op;
                lastCmd_ff <= wrByte;
                error_ff <= 8'h00;
                status_ff.busy <= 1'b1;
                status_ff.error <= 1'b0;
                status_ff.dataReq <= 1'b0;
                execCnt_ff <= ($bits(execCnt_ff))'(ata_cmd_pkg::EXEC_CYCLES);
            end else if (status_ff.busy) begin
                if (execCnt_ff > 1) begin
                    execCnt_ff <= execCnt_ff - 1'b1;
                end else begin
                    execCnt_ff <= '0;
                    status_ff.busy <= 1'b0;
                    unique case (op_ff)
                        ata_cmd_pkg::OP_BAD: begin
                            status_ff.error <= 1'b1;
                            error_ff <= ata_cmd_pkg::ERR_ABORT;
                        end
                        ata_cmd_pkg::OP_DIAG: error_ff <= ata_cmd_pkg::DIAG_PASS;
                        ata_cmd_pkg::OP_POWER: ;
                        ata_cmd_pkg::OP_IDENTIFY: begin
                            status_ff.dataReq <= 1'b1;
                            wordCnt_ff <= WCW'(ata_cmd_pkg::SECTOR_WORDS);
                        end
                        ata_cmd_pkg::OP_FORMAT: begin
                            status_ff.dataReq <= 1'b1;
                            wordCnt_ff <= WCW'(ata_cmd_pkg::SECTOR_WORDS);
                        end
                        default: begin
                            // Only range-checked parameters reach media
                            if (rangeBad) begin
                                status_ff.error <= 1'b1;
                                error_ff <= ata_cmd_pkg::ERR_RANGE;
                            end else begin
                                mediaOp_ff <= 4'(op_ff);
                                mediaStrobe_ff <= op_ff != ata_cmd_pkg::OP_WRITE;
                                if (op_ff == ata_cmd_pkg::OP_READ || op_ff == ata_cmd_pkg::OP_WRITE) begin
                                    status_ff.dataReq <= 1'b1;
                                    wordCnt_ff <= WCW'(ata_cmd_pkg::SECTOR_WORDS);
                                end
                            end
                        end
                    endcase
                end
            end else if ((dataWrite || dataRead) && wordCnt_ff != '0) begin
                wordCnt_ff <= wordCnt_ff - 1'b1;
                if (wordCnt_ff == WCW'(1)) begin
                    status_ff.dataReq <= 1'b0;
                    if (op_ff == ata_cmd_pkg::OP_WRITE) begin
                        mediaOp_ff <= 4'(op_ff);
                        mediaStrobe_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // Format keeps sector data: records geometry only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            recCyl_ff <= 16'h0000;
            recHead_ff <= 4'h0;
        end else if (cmdAccept && nxt_op == ata_cmd_pkg::OP_FORMAT) begin
            recCyl_ff <= taskFile_ff.cylinder;
            recHead_ff <= taskFile_ff.drvHead[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            powerMode_ff <= ata_cmd_pkg::POWER_ACTIVE;
        end else begin
            powerMode_ff <= ata_cmd_pkg::POWER_ACTIVE;
        end
    end

    // Interrupt: completion sets pending; set beats clear by status read
    always_ff @(posedge ref_clk) begin
        if (rst || soft_reset_bit) begin
            intPending_ff <= 1'b0;
        end else if (status_ff.busy && execCnt_ff <= 1 && !cmdAccept) begin
            intPending_ff <= 1'b1;
        end else if (statusRead) begin
            intPending_ff <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqReq_ff <= 1'b0;
        end else begin
            irqReq_ff <= intPending_ff && !ctl_ff[ata_cmd_pkg::INT_DISABLE_POS];
        end
    end

    chk_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
        irqReq_ff |-> !$past(ctl_ff[ata_cmd_pkg::INT_DISABLE_POS])) else $error("irq while disabled");
    chk_soft_reset_bit_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $past(soft_reset_bit) |-> taskFile_ff.drvHead == ata_cmd_pkg::DRVHEAD_RESET) else $error("task file not reset");
    chk_cfg_keep: assert property (@(posedge ref_clk) disable iff (rst)
        soft_reset_bit && $past(soft_reset_bit) && !$past(wrFire && awAddr_ff == ata_cmd_pkg::ADDR_CONFIG) |-> $stable(config_ff))
        else $error("config changed in soft reset");
    chk_ctl_fixed: assert property (@(posedge ref_clk) disable iff (rst)
        ctl_ff[3] && !ctl_ff[0] && ctl_ff[7:4] == 4'h0) else $error("control fixed bits wrong");
    chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (rst || soft_reset_bit)
        status_ff.busy && execCnt_ff > 1 |=> $stable(lastCmd_ff)) else $error("command taken while busy");
    chk_bad_error: assert property (@(posedge ref_clk) disable iff (rst || soft_reset_bit)
        cmdAccept && nxt_op == ata_cmd_pkg::OP_BAD |-> ##[1:12] status_ff.error && !mediaStrobe_ff)
        else $error("bad code without error");
    chk_status_clr: assert property (@(posedge ref_clk) disable iff (rst || soft_reset_bit)
        statusRead && !(status_ff.busy && execCnt_ff <= 1) |=> !intPending_ff) else $error("status read kept irq");
    chk_range_guard: assert property (@(posedge ref_clk) disable iff (rst)
        mediaStrobe_ff && mediaOp_ff != 4'(ata_cmd_pkg::OP_WRITE) |-> !$past(rangeBad))
        else $error("media op out of range");
    chk_echo_inv: assert property (@(posedge ref_clk) disable iff (rst)
        rdFire && arAddr_ff == ata_cmd_pkg::ADDR_HEADECHO |=> s_axi_rdata[5:2] == ~$past(taskFile_ff.drvHead[3:0]))
        else $error("head echo wrong");

    cov_identify: cover property (@(posedge ref_clk) cmdAccept && nxt_op == ata_cmd_pkg::OP_IDENTIFY);
    cov_format: cover property (@(posedge ref_clk) op_ff == ata_cmd_pkg::OP_FORMAT && dataWrite);
    cov_bad: cover property (@(posedge ref_clk) cmdAccept && nxt_op == ata_cmd_pkg::OP_BAD);
    cov_irq: cover property (@(posedge ref_clk) irqReq_ff);
endmodule : ata_card_command_and_control

// >>> rtl/ata_cmd_pkg.sv
// Package: register map, codes and constants for the ATA command block
package ata_cmd_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_FEATURE = 8'h04;
    localparam logic [7:0] ADDR_SECCOUNT = 8'h08;
    localparam logic [7:0] ADDR_SECNUM = 8'h0c;
    localparam logic [7:0] ADDR_CYLLOW = 8'h10;
    localparam logic [7:0] ADDR_CYLHIGH = 8'h14;
    localparam logic [7:0] ADDR_DRVHEAD = 8'h18;
    localparam logic [7:0] ADDR_CMDSTAT = 8'h1c;
    localparam logic [7:0] ADDR_CTLALT = 8'h20;
    localparam logic [7:0] ADDR_HEADECHO = 8'h24;
    localparam logic [7:0] ADDR_CONFIG = 8'h28;
    localparam logic [7:0] ADDR_CMDINFO = 8'h2c;
    localparam logic [7:0] ADDR_MODE = 8'h30;

    localparam int SOFT_RESET_POS = 2;
    localparam int INT_DISABLE_POS = 1;
    localparam int CARD_SELECT_POS = 4;
    localparam logic [7:0] DRVHEAD_RESET = 8'ha0;
    localparam logic [7:0] CTL_RESET = 8'h08;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] SECCOUNT_RESET = 8'h01;
    localparam logic [7:0] SECNUM_RESET = 8'h01;
    localparam logic [7:0] SECNUM_MIN = 8'h01;
    localparam logic [7:0] SECNUM_MAX = 8'h20;
    localparam logic [3:0] HEAD_MAX = 4'h3;
    localparam logic [7:0] POWER_ACTIVE = 8'hff;
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_RANGE = 8'h10;
    localparam int SECTOR_WORDS = 256;

    localparam real EXEC_TIME_NS = 100.0;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam int EXEC_CYCLES = (int'($floor(EXEC_TIME_NS / CLK_PERIOD_NS)) < 1) ? 1
                                 : int'($floor(EXEC_TIME_NS / CLK_PERIOD_NS));

    localparam logic [7:0] CMD_CHECK_POWER_A = 8'he5;
    localparam logic [7:0] CMD_CHECK_POWER_B = 8'h98;
    localparam logic [7:0] CMD_DIAGNOSE = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'hc0;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam logic [7:0] CMD_IDENTIFY = 8'hec;
    localparam logic [7:0] CMD_READ_MULTI = 8'hc4;
    localparam logic [7:0] CMD_READ_LONG_A = 8'h22;
    localparam logic [7:0] CMD_READ_LONG_B = 8'h23;
    localparam logic [7:0] CMD_READ_A = 8'h20;
    localparam logic [7:0] CMD_READ_B = 8'h21;
    localparam logic [7:0] CMD_VERIFY_A = 8'h40;
    localparam logic [7:0] CMD_VERIFY_B = 8'h41;
    localparam logic [7:0] CMD_WRITE_MULTI = 8'hc5;
    localparam logic [7:0] CMD_WRITE_MULTI_NE = 8'hcd;
    localparam logic [7:0] CMD_WRITE_NE = 8'h38;
    localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3c;

    typedef enum logic [3:0] {
        OP_NONE, OP_POWER, OP_DIAG, OP_ERASE, OP_FORMAT, OP_IDENTIFY,
        OP_READ, OP_VERIFY, OP_WRITE, OP_BAD
    } op_t;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] secCount;
        logic [7:0] secNum;
        logic [15:0] cylinder;
        logic [7:0] drvHead;
    } task_file_t;

    typedef struct packed {
        logic busy;
        logic ready;
        logic seekDone;
        logic dataReq;
        logic error;
    } status_t;
endpackage : ata_cmd_pkg

// >>> testbench/media_model.sv
// Media-side model: counts the media operations the card issues
`timescale 1ns/1ps
module media_model (
    input wire logic ref_clk,
    input wire logic mediaStrobe_ff,
    output int opCount = 0
);
    always @(posedge ref_clk) begin
        if (mediaStrobe_ff) opCount <= opCount + 1;
    end
endmodule : media_model

// >>> testbench/tb_top.sv
// Testbench: register, command and reset scenarios for the ATA block
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, d;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, irq, strobe;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [3:0] op;
    int n_mismatch = 0, n_checks = 0, cyc = 0, opCount;
    always #5 ref_clk = ~ref_clk;
    ata_card_command_and_control u_ata_card_command_and_control (
        .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .irqReq_ff(irq), .mediaOp_ff(op), .mediaStrobe_ff(strobe));
    media_model u_media_model (.ref_clk(ref_clk), .mediaStrobe_ff(strobe), .opCount(opCount));
    // Whole run needs a few thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        awAddr <= a;
        wData <= {24'h0, v};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        d = rData[7:0];
        rReady <= 1'b0;
    endtask : rd
    // Polls the alternate copy so a pending interrupt survives
    task automatic idle();
        rd(8'h20);
        while (d[7]) rd(8'h20);
    endtask : idle
    task automatic s_echo();
        for (int h = 0; h < 4; h++) begin
            wr(8'h18, 8'ha0 | 8'(h));
            rd(8'h24);
            chk(d & 8'h3c, {2'b00, ~4'(h), 2'b00});
        end
    endtask : s_echo
    task automatic s_erase();
        int n0;
        n0 = opCount;
        wr(8'h20, 8'h08);
        wr(8'h08, 8'h00);
        wr(8'h0c, ata_cmd_pkg::SECNUM_MAX);
        wr(8'h1c, ata_cmd_pkg::CMD_ERASE);
        idle();
        chk(8'(opCount - n0), 8'h01);
        chk({4'h0, op}, {4'h0, ata_cmd_pkg::OP_ERASE});
        chk({7'h0, irq}, 8'h01);
        rd(8'h1c);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, irq}, 8'h00);
    endtask : s_erase
    task automatic s_mask();
        wr(8'h20, 8'h0a);
        wr(8'h1c, ata_cmd_pkg::CMD_CHECK_POWER_B);
        idle();
        chk({7'h0, irq}, 8'h00);
        rd(8'h30);
        chk(d, ata_cmd_pkg::POWER_ACTIVE);
        wr(8'h20, 8'hf8);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, irq}, 8'h01);
        rd(8'h1c);
    endtask : s_mask
    task automatic s_err();
        int n0;
        n0 = opCount;
        wr(8'h1c, ata_cmd_pkg::CMD_DIAGNOSE);
        idle();
        rd(8'h04);
        chk(d, ata_cmd_pkg::DIAG_PASS);
        wr(8'h1c, 8'hff);
        idle();
        rd(8'h04);
        chk(d, ata_cmd_pkg::ERR_ABORT);
        wr(8'h0c, 8'h21);
        wr(8'h1c, ata_cmd_pkg::CMD_READ_A);
        idle();
        rd(8'h1c);
        chk(d & 8'h01, 8'h01);
        chk(8'(opCount - n0), 8'h00);
    endtask : s_err
    task automatic s_sel();
        wr(8'h18, 8'hb0);
        wr(8'h1c, ata_cmd_pkg::CMD_DIAGNOSE);
        rd(8'h1c);
        chk(d & 8'h80, 8'h00);
        wr(8'h18, 8'ha0);
        wr(8'h1c, ata_cmd_pkg::CMD_DIAGNOSE);
        wr(8'h1c, 8'hff);
        idle();
        rd(8'h04);
        chk(d, ata_cmd_pkg::DIAG_PASS);
    endtask : s_sel
    task automatic s_ident();
        wr(8'h1c, ata_cmd_pkg::CMD_IDENTIFY);
        idle();
        for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++) begin
            rd(8'h00);
            if (i == 6) chk(d, ata_cmd_pkg::SECNUM_MAX);
        end
        rd(8'h1c);
        chk(d & 8'h08, 8'h00);
    endtask : s_ident
    task automatic s_format();
        int n0;
        wr(8'h10, 8'h5c);
        wr(8'h18, 8'ha2);
        wr(8'h1c, ata_cmd_pkg::CMD_FORMAT);
        idle();
        chk(d & 8'h08, 8'h08);
        n0 = opCount;
        for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++) wr(8'h00, 8'(i));
        rd(8'h1c);
        chk(d & 8'h08, 8'h00);
        rd(8'h2c);
        chk(d, 8'h5c);
        chk(8'(opCount - n0), 8'h00);
        wr(8'h0c, 8'h01);
        wr(8'h1c, ata_cmd_pkg::CMD_WRITE_NE);
        idle();
        n0 = opCount;
        for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++) wr(8'h00, 8'(i));
        // Model counts one edge after the strobe
        @(posedge ref_clk);
        chk(8'(opCount - n0), 8'h01);
        chk({4'h0, op}, {4'h0, ata_cmd_pkg::OP_WRITE});
        wr(8'h1c, ata_cmd_pkg::CMD_READ_MULTI);
        idle();
        chk({4'h0, op}, {4'h0, ata_cmd_pkg::OP_READ});
    endtask : s_format
    task automatic s_soft_reset_bit();
        wr(8'h28, 8'h5a);
        wr(8'h20, 8'h0c);
        wr(8'h08, 8'h33);
        wr(8'h20, 8'h08);
        rd(8'h08);
        chk(d, ata_cmd_pkg::SECCOUNT_RESET);
        rd(8'h28);
        chk(d, 8'h5a);
    endtask : s_soft_reset_bit
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        s_echo();
        s_erase();
        s_mask();
        s_err();
        s_sel();
        s_ident();
        s_format();
        s_soft_reset_bit();
        end_sim();
    end
endmodule : tb_top
